/* test/i2c_bus_partner.sv */
// Purpose: behavioural slave on the two-wire bus
// Assumes: lines resolved with pull-ups in the bench
// Notes: slow holds the clock low in mid-byte
`timescale 1ns/1ns

module i2c_bus_partner
#(
	parameter [6:0] addr = 7'h50,
	parameter [7:0] tx_byte = 8'h5A
)
(
	input wire scl,
	input wire sda,
	input wire slow,
	output reg scl_oe,
	output reg sda_oe,
	output reg [7:0] rx_last
);
	integer cnt; // clock falls in byte
	reg [7:0] sh; // shifted-in bits
	reg act, first, hit, rd, mack; // frame state
	initial
	begin
		{act, first, hit, rd, mack, scl_oe, sda_oe} = 7'h00;
		{cnt, sh, rx_last} = 48'h0;
	end
	// start and stop detect
	always @(negedge sda)
		if (scl)
		begin
			{act, first, hit, rd, sda_oe} = 5'h18;
			cnt = -1; // the clock fall closing the start brings this to 0
		end
	always @(posedge sda)
		if (scl)
		begin
			act = 1'b0;
			sda_oe = 1'b0;
		end
	// sample on clock rise
	always @(posedge scl)
		if (act && cnt < 8)
			sh = {sh[6:0], sda};
		else if (act && rd && sda)
			mack = 1'b0;
	// drive on clock fall
	always @(negedge scl)
		if (act)
		begin
			cnt = cnt + 1;
			if (cnt == 8 && first)
			begin
				hit = (sh[7:1] == addr);
				rd = hit && sh[0];
				mack = 1'b1;
				sda_oe = hit;
			end
			else if (cnt == 8)
			begin
				if (hit && !rd)
					rx_last = sh;
				sda_oe = hit && !rd;
			end
			else
			begin
				if (cnt == 9)
				begin
					cnt = 0;
					first = 1'b0;
				end
				sda_oe = rd && mack && !tx_byte[7 - cnt];
			end
			if (cnt == 4 && slow)
			begin
				scl_oe = 1'b1;
				#3000 scl_oe = 1'b0;
			end
		end
endmodule // i2c_bus_partner

/* test/i2c_mm_checker_sva.sv */
// Purpose: port checks on the two-wire controller
// Assumes: one aclk domain, aresetn synchronous active low
// Notes: bound onto every controller instance
`timescale 1ns/1ns

module i2c_mm_checker
(
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire scl_i,
	input wire scl_o,
	input wire scl_oe,
	input wire sda_i,
	input wire sda_o,
	input wire sda_oe
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////
	// aligned write, both halves at one edge
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_awaddr[1:0];
	endsequence
	// aligned read taken
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready && !s_axi_araddr[1:0];
	endsequence
	// both halves are held one edge, the answer rises at the next
	property p_b_after;
		s_wr_take |=> ##1 s_axi_bvalid
			&& s_axi_bresp == ($past(s_axi_awaddr, 2) > 5'h10 ? 2'h2 : 2'h0);
	endproperty
	a_b_after: assert property (p_b_after) else $error("write answer wrong");
	property p_r_after;
		s_rd_take |=> s_axi_rvalid && !s_axi_arready && s_axi_rdata[31:8] == 24'h000000
			&& s_axi_rresp == ($past(s_axi_araddr) > 5'h10 ? 2'h2 : 2'h0);
	endproperty
	a_r_after: assert property (p_r_after) else $error("read answer wrong");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_refuse;
		(s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) and (s_axi_rvalid |-> !s_axi_arready);
	endproperty
	a_refuse: assert property (p_refuse) else $error("request taken while answer pending");
	////////////////////////////////////////////////////////////////
	// open drain: only the enables move
	property p_pins;
		!scl_o && !sda_o;
	endproperty
	a_pins: assert property (p_pins) else $error("line driven high");
	property p_start_free;
		$rose(sda_oe) && !scl_oe && $past(scl_i) |-> $past(sda_i);
	endproperty
	a_start_free: assert property (p_start_free) else $error("start on busy data line");
	property p_sda_steady;
		$changed(scl_oe) |-> $stable(sda_oe);
	endproperty
	a_sda_steady: assert property (p_sda_steady) else $error("data moved at clock edge");
endmodule // i2c_mm_checker

bind i2c_multimaster i2c_mm_checker i2c_mm_checker_inst (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe(sda_oe));

/* test/i2c_multimaster_protocol_test.sv */
// Purpose: self-checking bench for the two-wire controller
// Assumes: 10 MHz aclk, bench master clock of 800 ns
// Notes: own address 0x21, partner at 0x50
`timescale 1ns/1ns
`include "i2c_mm_regs.vh"

module i2c_multimaster_protocol_test;
	reg aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r, scl_pull, sda_pull, slow;
	reg [4:0] aw_a, ar_a; // bus addresses
	reg [31:0] w_d; // write data
	reg [7:0] rd_val; // last read byte
	reg [1:0] resp; // last response
	wire aw_rdy, w_rdy, b_v, ar_rdy, r_v, d_scl_oe, d_sda_oe, p_scl_oe, p_sda_oe, irq;
	wire [1:0] b_resp, r_resp;
	wire [31:0] r_d;
	wire [7:0] rx_last;
	integer n_mismatch, cmp_count, i;
	// wired-and lines with pull-ups
	wire scl = !(d_scl_oe || p_scl_oe || scl_pull);
	wire sda = !(d_sda_oe || p_sda_oe || sda_pull);
	i2c_multimaster i2c_multimaster_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
		.s_axi_awprot(3'h0), .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
		.s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
		.s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
		.s_axi_rvalid(r_v), .s_axi_rready(r_r), .scl_i(scl), .scl_o(), .scl_oe(d_scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe(d_sda_oe), .irq(irq));
	i2c_bus_partner i2c_bus_partner_inst (.scl(scl), .sda(sda), .slow(slow), .scl_oe(p_scl_oe),
		.sda_oe(p_sda_oe), .rx_last(rx_last));
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////
	task check(input string nm, input [31:0] seen, input [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			n_mismatch = n_mismatch + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// register write, halves released once taken
	task wr(input [4:0] a, input [7:0] d);
		reg ta, tw, tb;
		@(posedge aclk);
		{aw_a, w_d, aw_v, w_v, b_r} <= {a, 24'h000000, d, 3'h7};
		tb = 1'b0;
		while (!tb)
		begin
			@(negedge aclk);
			{ta, tw, tb, resp} = {aw_v && aw_rdy, w_v && w_rdy, b_v, b_resp};
			@(posedge aclk);
			if (ta) aw_v <= 1'b0;
			if (tw) w_v <= 1'b0;
		end
		b_r <= 1'b0;
	endtask
	// register read
	task rd(input [4:0] a);
		reg ta, tr;
		@(posedge aclk);
		{ar_a, ar_v, r_r} <= {a, 2'h3};
		tr = 1'b0;
		while (!tr)
		begin
			@(negedge aclk);
			{ta, tr, rd_val, resp} = {ar_v && ar_rdy, r_v, r_d[7:0], r_resp};
			@(posedge aclk);
			if (ta) ar_v <= 1'b0;
		end
		r_r <= 1'b0;
	endtask
	task chk_rd(input string nm, input [4:0] a, input [7:0] exp);
		rd(a);
		check(nm, rd_val, exp);
	endtask
	// poll for event, then clear it
	task wait_evt;
		i = 0;
		do begin rd(`OFS_STAT); i = i + 1; end while (!rd_val[1] && i < 400);
		check("irq", irq, 1);
		wr(`OFS_STAT, 8'h00);
	endtask
	task wait_idle;
		i = 0;
		do begin rd(`OFS_STAT); i = i + 1; end while (rd_val[5] && i < 400);
		check("busy clear", rd_val[5], 0);
	endtask
	// bench master on the lines, off the aclk edges
	task m_byte(input [7:0] b, output reg ack);
		integer k;
		#13 sda_pull = 1'b1;
		#400 scl_pull = 1'b1;
		for (k = 8; k >= 0; k = k - 1)
		begin
			#200 sda_pull = (k > 0) ? !b[k - 1] : 1'b0;
			#200 scl_pull = 1'b0;
			#200 ack = sda;
			#200 scl_pull = 1'b1;
		end
	endtask
	task m_stop;
		sda_pull = 1'b1;
		#200 scl_pull = 1'b0;
		#400 sda_pull = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////
	task t_regs;
		chk_rd("status", `OFS_STAT, `STAT_RESET);
		chk_rd("control", `OFS_CTRL, `CTRL_RESET);
		chk_rd("rate", `OFS_RATE, 8'h00);
		rd(5'h14);
		check("rd resp", resp, `RESP_SLVERR);
		wr(5'h18, 8'hFF);
		check("wr resp", resp, `RESP_SLVERR);
		wr(`OFS_RATE, 8'hFF);
		chk_rd("rate", `OFS_RATE, 8'h1F);
		wr(`OFS_RATE, 8'h00);
		wr(`OFS_OWN_ADDR, 8'h43);
		chk_rd("own", `OFS_OWN_ADDR, 8'h42);
	endtask
	task t_mwrite;
		slow <= 1'b1;
		wr(`OFS_CTRL, 8'hF0);
		wr(`OFS_DATA, 8'hA0);
		wait_evt;
		check("addr ack", rd_val[0], 0);
		check("busy", rd_val[5], 1);
		wr(`OFS_DATA, 8'h3C);
		wait_evt;
		check("done", rd_val[7], 1);
		check("rx byte", rx_last, 8'h3C);
		wr(`OFS_CTRL, 8'hC0);
		wait_idle;
		slow <= 1'b0;
	endtask
	task t_read;
		wr(`OFS_CTRL, 8'hF0);
		wr(`OFS_DATA, 8'hB2);
		wait_evt;
		check("nack", rd_val[0], 1);
		wr(`OFS_CTRL, 8'hF4);
		wr(`OFS_DATA, 8'hA1);
		wait_evt;
		check("read ack", rd_val[0], 0);
		wr(`OFS_CTRL, 8'hE8);
		rd(`OFS_DATA);
		wait_evt;
		wr(`OFS_CTRL, 8'hC0);
		wait_idle;
		chk_rd("rd byte", `OFS_DATA, 8'h5A);
	endtask
	task t_arb;
		@(posedge aclk) sda_pull <= 1'b1;
		wr(`OFS_CTRL, 8'hF0);
		wait_evt;
		check("lost", rd_val[4], 1);
		chk_rd("ctrl", `OFS_CTRL, 8'hC0);
		check("no drive", {d_scl_oe, d_sda_oe}, 0);
		@(posedge aclk) sda_pull <= 1'b0;
		wait_idle;
	endtask
	task t_slave;
		reg ack;
		wr(`OFS_DATA, 8'hFF);
		for (integer c = 0; c < 3; c = c + 1)
		begin
			m_byte(8'h42 + c[7:0], ack);
			check("slave ack", ack, c == 2);
			if (c < 2)
			begin
				wait_evt;
				check("addressed", rd_val[6], 1);
				check("srw", rd_val[2], c[0]);
			end
			m_stop;
			wait_idle;
		end
	endtask
	////////////////////////////////////////////////////////////////
	task results;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// main sequence
	initial
	begin
		{aresetn, aw_v, w_v, b_r, ar_v, r_r, scl_pull, sda_pull, slow} = 9'h000;
		{aw_a, ar_a, w_d, n_mismatch, cmp_count} = 106'h0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_mwrite;
		t_read;
		t_arb;
		t_slave;
		results;
	end
	// hang guard
	initial
	begin
		#6000000 n_mismatch = n_mismatch + 1;
		results;
	end
endmodule // i2c_multimaster_protocol_test

/* verilog/bit_rate_divider.v */
// Purpose: half-period tick for the serial clock, from a 32-entry divider table
// Assumes: one clock domain, synchronous active-low reset
// Notes: restart realigns the tick to the current cycle
`timescale 1ns/1ns

module bit_rate_divider
(
	input wire aclk,
	input wire aresetn,
	input wire [4:0] rate_sel,
	input wire restart,
	output reg tick
);

	reg [11:0] count_reg; // cycles since last tick

	// full divider from the five rate bits, halved for one serial clock phase
	function [11:0] half_period;
		input [4:0] sel;
		reg [12:0] div;
		begin
			case (sel[3:0])
				4'h0: div = 13'h0016;
				4'h1: div = 13'h0018;
				4'h2: div = 13'h001C;
				4'h3: div = 13'h0022;
				4'h4: div = 13'h002C;
				4'h5: div = 13'h0030;
				4'h6: div = 13'h0038;
				4'h7: div = 13'h0044;
				4'h8: div = 13'h0058;
				4'h9: div = 13'h0060;
				4'hA: div = 13'h0070;
				4'hB: div = 13'h0088;
				4'hC: div = 13'h00B0;
				4'hD: div = 13'h00C0;
				4'hE: div = 13'h00E0;
				default: div = 13'h0110;
			endcase
			// upper half of the table is the lower half times sixteen
			if (sel[4])
				div = {div[8:0], 4'h0};
			half_period = div[12:1];
		end
	endfunction

	//////////////////////////////////////////////////////////////////////
	// free-running counter, one-cycle tick every half period
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			count_reg <= 12'h000;
			tick <= 1'b0;
		end
		else if (restart)
		begin
			count_reg <= 12'h000;
			tick <= 1'b0;
		end
		else if (count_reg >= half_period(rate_sel) - 12'h001)
		begin
			count_reg <= 12'h000;
			tick <= 1'b1;
		end
		else
		begin
			count_reg <= count_reg + 12'h001;
			tick <= 1'b0;
		end
	end

endmodule // bit_rate_divider

/* verilog/i2c_mm_regs.vh */
// Purpose: register offsets, bit positions and reset values of the two-wire bus controller
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register, data in bits 7:0
// Notes: definitions only
`ifndef I2C_MM_REGS_VH
`define I2C_MM_REGS_VH

// register byte offsets
`define OFS_OWN_ADDR 5'h00
`define OFS_RATE 5'h04
`define OFS_CTRL 5'h08
`define OFS_STAT 5'h0C
`define OFS_DATA 5'h10

// control register bit positions
`define CTRL_EN 7
`define CTRL_IEN 6
`define CTRL_MS 5
`define CTRL_TX 4
`define CTRL_ACKDIS 3
`define CTRL_RESTART 2

// status register bit positions
`define STAT_DONE 7
`define STAT_ADDR 6
`define STAT_BUSY 5
`define STAT_ARB 4
`define STAT_SRW 2
`define STAT_EVT 1
`define STAT_RXACK 0

// reset values
`define CTRL_RESET 8'h00
`define STAT_RESET 8'h81
`define OWN_RESET 8'h00
`define RATE_RESET 5'h00

// byte framing counts
`define LAST_DATA_BIT 4'h7
`define ACK_COUNT 4'h8
`define BYTE_CLOCKS 4'h9

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* verilog/i2c_multimaster.v */
// Purpose: multi-master two-wire serial controller with AXI4-Lite register access
// Assumes: aclk 10 MHz, synchronous active-low aresetn, bus lines open drain
// Notes: scl and sda are sampled by two flops before any logic reads them
// Operation
// - start only on free bus, sda falls
// - stop: sda rises while scl high
// - first byte: seven-bit address plus direction
// - matching slave acknowledges on ninth clock
// - eight data bits, msb first, chosen direction
// - sda changes only while scl low
// - every byte followed by acknowledge, nine clocks
// - slave nack leaves sda high; stop/restart
// - master nack: slave transmitter releases sda
// - repeated start without preceding stop
// - shared scl: longest low, shortest high
// - losing master drops to slave receive
// - no stop on loss; arbitration flag set
// - event after byte, loss, own address
// - thirty-two rates, selectable acknowledge
// - master select rise starts, fall stops
// - busy set on start, cleared on stop
// - ack disable bit suppresses receive acknowledge; the code still acknowledges an own-address match
`timescale 1ns/1ns
`include "i2c_mm_regs.vh"

module i2c_multimaster
(
	input wire aclk,
	input wire aresetn,
	input wire [4:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [4:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire scl_i,
	output reg scl_o,
	output reg scl_oe,
	input wire sda_i,
	output reg sda_o,
	output reg sda_oe,
	output reg irq
);

	// master sequencer states
	localparam M_IDLE = 4'h0;
	localparam M_START = 4'h1;
	localparam M_WAIT = 4'h2;
	localparam M_LOW = 4'h3;
	localparam M_HIGH = 4'h4;
	localparam M_STOP = 4'h5;
	localparam M_STOP2 = 4'h6;
	localparam M_RS = 4'h7;
	localparam M_RS2 = 4'h8;

	reg scl_m, scl_s, scl_d; // scl synchroniser and edge history
	reg sda_m, sda_s, sda_d; // sda synchroniser and edge history
	reg [7:0] own_slave_address_reg; // own address in bits 7:1
	reg [4:0] rate_reg; // serial rate select
	reg [7:0] ctrl_reg; // enable, irq enable, master, tx, ack disable
	reg [7:0] data_reg; // transmit byte / last received byte
	reg [7:0] shift_reg; // incoming bits
	reg [3:0] bit_cnt; // scl rises seen in current byte
	reg in_frame, first_byte; // between start and stop; address byte
	reg done_reg, addressed_reg, bus_busy_flag, arbitration_lost_flag;
	reg srw_reg, evt_reg, rxack_reg;
	reg [3:0] mstate; // master sequencer
	reg seen_high; // our released scl has been seen high
	reg div_clr; // realign the phase divider
	reg go_reg, start_req, stop_req, rs_req; // pending software commands
	reg [4:0] awaddr_reg; // captured write address
	reg [7:0] wdata_reg; // captured write data
	reg wstrb0_reg, aw_have, w_have; // captured lane and channel flags
	reg [7:0] rd_val; // read mux value
	reg rd_ok; // read address mapped

	wire tick; // half serial clock period
	wire master_select_bit = ctrl_reg[`CTRL_MS];
	wire ack_disable_bit = ctrl_reg[`CTRL_ACKDIS];
	wire is_master = (mstate != M_IDLE);
	wire scl_rise = scl_s & ~scl_d;
	wire scl_fall = ~scl_s & scl_d;
	wire start_det = scl_s & scl_d & sda_d & ~sda_s;
	wire stop_det = scl_s & scl_d & ~sda_d & sda_s;
	wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
	wire transmitting = is_master ? ctrl_reg[`CTRL_TX]
		: (addressed_reg & srw_reg & ~first_byte);
	wire ack_wanted = is_master ? (~ctrl_reg[`CTRL_TX] & ~ack_disable_bit)
		: (first_byte ? addressed_reg : (addressed_reg & ~srw_reg & ~ack_disable_bit));
	wire [7:0] rx_byte = {shift_reg[6:0], sda_s};

	// line pulls low for a given bit of the byte
	function drive_low;
		input [7:0] byte_val;
		input [3:0] idx;
		begin
			drive_low = ~byte_val[3'h7 - idx[2:0]];
		end
	endfunction

	bit_rate_divider u_div
	(
		.aclk(aclk),
		.aresetn(aresetn),
		.rate_sel(rate_reg),
		.restart(div_clr),
		.tick(tick)
	);

	//////////////////////////////////////////////////////////////////////
	// register read mux
	always @*
	begin
		rd_ok = 1'b1;
		rd_val = 8'h00;
		case (s_axi_araddr)
			`OFS_OWN_ADDR: rd_val = own_slave_address_reg;
			`OFS_RATE: rd_val = {3'h0, rate_reg};
			`OFS_CTRL: rd_val = ctrl_reg;
			`OFS_STAT: rd_val = {done_reg, addressed_reg, bus_busy_flag,
				arbitration_lost_flag, 1'b0, srw_reg, evt_reg, rxack_reg};
			`OFS_DATA: rd_val = data_reg;
			default: rd_ok = 1'b0;
		endcase
	end

	//////////////////////////////////////////////////////////////////////
	// bus slave, byte engine and master sequencer
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			{scl_m, scl_s, scl_d, sda_m, sda_s, sda_d} <= 6'h3F;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_bvalid <= 1'b0;
			s_axi_arready <= 1'b1;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			awaddr_reg <= 5'h00;
			wdata_reg <= 8'h00;
			{wstrb0_reg, aw_have, w_have} <= 3'h0;
			own_slave_address_reg <= `OWN_RESET;
			rate_reg <= `RATE_RESET;
			ctrl_reg <= `CTRL_RESET;
			{done_reg, addressed_reg, bus_busy_flag, arbitration_lost_flag} <= 4'h8;
			{srw_reg, evt_reg, rxack_reg} <= 3'h1;
			data_reg <= 8'h00;
			shift_reg <= 8'h00;
			bit_cnt <= 4'h0;
			{in_frame, first_byte} <= 2'h0;
			mstate <= M_IDLE;
			{seen_high, div_clr} <= 2'h0;
			{go_reg, start_req, stop_req, rs_req} <= 4'h0;
			{scl_o, scl_oe, sda_o, sda_oe, irq} <= 5'h00;
		end
		else
		begin
			// two-flop synchronisers, third flop for edges
			scl_m <= scl_i;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= sda_i;
			sda_s <= sda_m;
			sda_d <= sda_s;
			div_clr <= 1'b0;

			// write address and data channels, either order
			if (s_axi_awvalid && s_axi_awready)
			begin
				awaddr_reg <= s_axi_awaddr;
				aw_have <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wdata_reg <= s_axi_wdata[7:0];
				wstrb0_reg <= s_axi_wstrb[0];
				w_have <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			// response handshake reopens both write channels
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			// register write once both halves are held
			if (wr_fire)
			begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case (awaddr_reg)
					`OFS_OWN_ADDR:
						if (wstrb0_reg)
							own_slave_address_reg <= {wdata_reg[7:1], 1'b0};
					`OFS_RATE:
						if (wstrb0_reg)
							rate_reg <= wdata_reg[4:0];
					`OFS_CTRL:
						if (wstrb0_reg)
						begin
							ctrl_reg <= {wdata_reg[7:3], 3'h0};
							addressed_reg <= 1'b0;
							if (wdata_reg[`CTRL_MS] && !master_select_bit)
								start_req <= 1'b1;
							if (!wdata_reg[`CTRL_MS] && master_select_bit)
								stop_req <= 1'b1;
							if (wdata_reg[`CTRL_RESTART] && wdata_reg[`CTRL_MS] && is_master)
								rs_req <= 1'b1;
						end
					`OFS_STAT:
						if (wstrb0_reg)
						begin
							// flags clear by writing zero
							if (!wdata_reg[`STAT_ARB])
								arbitration_lost_flag <= 1'b0;
							if (!wdata_reg[`STAT_EVT])
								evt_reg <= 1'b0;
						end
					`OFS_DATA:
						if (wstrb0_reg)
						begin
							data_reg <= wdata_reg;
							go_reg <= 1'b1;
						end
					default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end

			// read channel, data read releases next master receive byte
			if (s_axi_rvalid && s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			else if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rd_val};
				s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
				if (s_axi_araddr == `OFS_DATA && is_master && !ctrl_reg[`CTRL_TX])
					go_reg <= 1'b1;
			end

			// bus state from line conditions
			if (start_det)
			begin
				bus_busy_flag <= 1'b1;
				in_frame <= 1'b1;
				first_byte <= 1'b1;
				bit_cnt <= 4'h0;
				addressed_reg <= 1'b0;
			end
			else if (stop_det)
			begin
				bus_busy_flag <= 1'b0;
				in_frame <= 1'b0;
				addressed_reg <= 1'b0;
			end
			// sample on rising scl, data is stable while high
			else if (in_frame && scl_rise && bit_cnt < `BYTE_CLOCKS)
			begin
				shift_reg <= rx_byte;
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == 4'h0)
					done_reg <= 1'b0;
				if (bit_cnt == `LAST_DATA_BIT)
				begin
					if (!transmitting)
						data_reg <= rx_byte;
					if (first_byte && !is_master && rx_byte[7:1] == own_slave_address_reg[7:1])
					begin
						addressed_reg <= 1'b1;
						srw_reg <= rx_byte[0];
						evt_reg <= 1'b1;
					end
				end
				if (bit_cnt == `ACK_COUNT)
				begin
					rxack_reg <= sda_s;
					if (!is_master && transmitting && sda_s)
						addressed_reg <= 1'b0;
				end
			end
			// drive next bit on falling scl only
			else if (in_frame && scl_fall)
			begin
				if (bit_cnt == `BYTE_CLOCKS)
				begin
					bit_cnt <= 4'h0;
					first_byte <= 1'b0;
					done_reg <= 1'b1;
					evt_reg <= 1'b1;
					sda_oe <= transmitting & drive_low(data_reg, 4'h0);
				end
				else if (bit_cnt == `ACK_COUNT)
					sda_oe <= ack_wanted;
				else
					sda_oe <= transmitting & drive_low(data_reg, bit_cnt);
			end

			// master sequencer
			case (mstate)
				M_IDLE:
				begin
					stop_req <= 1'b0;
					rs_req <= 1'b0;
					go_reg <= 1'b0;
					if (start_req)
					begin
						start_req <= 1'b0;
						if (bus_busy_flag || !scl_s || !sda_s)
						begin
							// busy bus: fall back to slave receive
							ctrl_reg[`CTRL_MS] <= 1'b0;
							ctrl_reg[`CTRL_TX] <= 1'b0;
							arbitration_lost_flag <= 1'b1;
							evt_reg <= 1'b1;
						end
						else
						begin
							sda_oe <= 1'b1;
							div_clr <= 1'b1;
							mstate <= M_START;
						end
					end
				end
				M_START:
					if (tick)
					begin
						scl_oe <= 1'b1;
						mstate <= M_WAIT;
					end
				M_WAIT:
					// scl held low until software acts
					if (stop_req)
					begin
						stop_req <= 1'b0;
						sda_oe <= 1'b1;
						div_clr <= 1'b1;
						mstate <= M_STOP;
					end
					else if (rs_req)
					begin
						rs_req <= 1'b0;
						sda_oe <= 1'b0;
						div_clr <= 1'b1;
						mstate <= M_RS;
					end
					else if (go_reg)
					begin
						go_reg <= 1'b0;
						sda_oe <= ctrl_reg[`CTRL_TX] & drive_low(data_reg, 4'h0);
						div_clr <= 1'b1;
						mstate <= M_LOW;
					end
				M_LOW:
					if (tick)
					begin
						scl_oe <= 1'b0;
						seen_high <= 1'b0;
						mstate <= M_HIGH;
					end
				M_HIGH:
					// high time counts from seen rise; a stretching peer
					// lengthens low, an earlier peer fall ends high
					if (!seen_high)
					begin
						if (scl_s)
						begin
							seen_high <= 1'b1;
							div_clr <= 1'b1;
						end
					end
					else if (tick || !scl_s)
					begin
						scl_oe <= 1'b1;
						div_clr <= 1'b1;
						mstate <= (bit_cnt == `BYTE_CLOCKS) ? M_WAIT : M_LOW;
					end
				M_STOP:
					if (tick)
					begin
						scl_oe <= 1'b0;
						mstate <= M_STOP2;
					end
				M_STOP2:
					if (scl_s && tick)
					begin
						sda_oe <= 1'b0;
						mstate <= M_IDLE;
					end
				M_RS:
					if (tick)
					begin
						scl_oe <= 1'b0;
						mstate <= M_RS2;
					end
				M_RS2:
					if (scl_s && tick)
					begin
						sda_oe <= 1'b1;
						div_clr <= 1'b1;
						mstate <= M_START;
					end
				default: mstate <= M_IDLE;
			endcase

			// lost a data bit: release both lines, no stop
			if (is_master && in_frame && scl_rise && bit_cnt < `ACK_COUNT
				&& ctrl_reg[`CTRL_TX] && !sda_oe && !sda_s)
			begin
				mstate <= M_IDLE;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				ctrl_reg[`CTRL_MS] <= 1'b0;
				ctrl_reg[`CTRL_TX] <= 1'b0;
				arbitration_lost_flag <= 1'b1;
				evt_reg <= 1'b1;
			end

			// disabled interface leaves the lines alone
			if (!ctrl_reg[`CTRL_EN])
			begin
				mstate <= M_IDLE;
				scl_oe <= 1'b0;
				sda_oe <= 1'b0;
				in_frame <= 1'b0;
			end

			irq <= evt_reg & ctrl_reg[`CTRL_IEN];
		end
	end

endmodule // i2c_multimaster
